// File: adc_seq_pkg.sv
// Constants, field layouts and types shared by the serial shift sequencer.
// Assumes a 50 MHz system clock and a host shift clock far slower than it.
//
// Overview of operation
// - The serial result output floats while select is high and is driven while select is low.
// - Once select is low the first bit of the previous result appears on the serial output.
// - Every later falling shift clock edge moves the output on to the next bit in order.
// - The remaining 11 result bits leave on the falling edges after the first bit.
// - The end-of-conversion flag falls after the last falling shift clock edge of a transfer.
// - The end-of-conversion flag stays low until the new result is ready, then rises.
// - The eight command bits from the host are captured on the first eight rising edges.
// - The channel address goes to the input multiplexer once the fourth rising edge took it.
// - Sampling starts on the fourth falling edge and lasts until the last falling edge.
// - The last falling edge hands control to the internal converter sequence.
// - Select high holds the bit counters clear; select going low starts a frame and enables the port.
// - The 4-bit channel address arrives most significant bit first on the first four rises.
package adc_seq_pkg;

   // Word sizes
   localparam int RESULT_BITS = 12;
   localparam int CMD_BITS    = 8;
   localparam int ADDR_BITS   = 4;
   localparam int CNT_BITS    = 4;

   // Edge counts within one transfer
   localparam logic [CNT_BITS-1:0] ADDR_RISE   = 4'h4;
   localparam logic [CNT_BITS-1:0] CMD_RISE    = 4'h8;
   localparam logic [CNT_BITS-1:0] SAMPLE_FALL = 4'h4;
   localparam logic [CNT_BITS-1:0] LAST_FALL   = 4'hc;
   localparam logic [CNT_BITS-1:0] LAST_INDEX  = 4'hb;
   localparam logic [CNT_BITS-1:0] CNT_ZERO    = 4'h0;
   localparam logic [CNT_BITS-1:0] CNT_ONE     = 4'h1;

   // Reset values
   localparam logic [RESULT_BITS-1:0] RESULT_RESET = 12'h000;
   localparam logic [ADDR_BITS-1:0]   ADDR_RESET   = 4'h0;
   localparam logic [CMD_BITS-1:0]    CMD_RESET    = 8'h00;

   // Command byte layout, first bit received lands in bit 7
   typedef struct packed {
      logic [ADDR_BITS-1:0] addr;      // Channel address, MSB first
      logic [1:0]           length;    // Output length code, carried only
      logic                 lsb_first; // Output order for later transfers
      logic                 bipolar;   // Output coding, carried only
   } cmd_t;

   // Requests toward the analog front end and converter core
   typedef struct packed {
      logic [ADDR_BITS-1:0] mux_addr;
      logic                 sample_en;
      logic                 conv_start;
   } conv_req_t;

   // Answer from the converter core
   typedef struct packed {
      logic                   done;
      logic [RESULT_BITS-1:0] data;
   } conv_res_t;

   // Control state of the system-clock side
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SHIFT,
      ST_CONVERT
   } seq_state_t;

endpackage

// File: sync_2ff.sv
// Two-stage synchroniser for levels and toggles entering the system clock.
// Assumes each bit changes slowly enough to be sampled on its own.
`timescale 1ns/1ps
module sync_2ff #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // Level in and level out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stage1_reg <= '0;
         sync_out   <= '0;
      end else begin
         stage1_reg <= async_in;
         sync_out   <= stage1_reg;
      end
   end

endmodule

// File: adc_serial_shift_sequencer.sv
// Serial host port and conversion hand-off sequencer of a sampling converter.
// Assumes the core answers a start pulse with a one-cycle done and a result,
// and that the shift clock runs only while select is low.
`timescale 1ns/1ps
module adc_serial_shift_sequencer
   import adc_seq_pkg::*;
(
   // System clock and reset
   input  wire logic                   clk,
   input  wire logic                   resetn,
   // Host serial port, shift clock domain
   input  wire logic                   sclk,
   input  wire logic                   csn,
   input  wire logic                   sdi,
   output logic                        sdo,
   output logic                        sdo_oe,
   output logic                        eoc,
   // Converter core
   input  wire adc_seq_pkg::conv_res_t conv_res,
   output adc_seq_pkg::conv_req_t      conv_req
);
   import adc_seq_pkg::*;

   // Shift clock domain state
   logic                 link_clr;
   logic [CNT_BITS-1:0]  rise_cnt_reg;
   logic [CMD_BITS-1:0]  cmd_shift_reg;
   logic [ADDR_BITS-1:0] addr_hold_reg;
   logic [CMD_BITS-1:0]  cmd_hold_reg;
   logic                 addr_tog_reg;
   logic                 cmd_tog_reg;
   logic                 fall_tog_reg;

   // Synchronised views in the system clock domain
   logic                 sel_s;
   logic                 addr_tog_s;
   logic                 cmd_tog_s;
   logic                 fall_tog_s;
   logic                 addr_tog_d_reg;
   logic                 cmd_tog_d_reg;
   logic                 fall_tog_d_reg;

   // System clock domain state
   seq_state_t             state_reg;
   seq_state_t             state_next;
   logic [CNT_BITS-1:0]    fall_cnt_reg;
   logic [CNT_BITS-1:0]    fall_cnt_next;
   logic [RESULT_BITS-1:0] result_reg;
   logic                   lsb_first_reg;
   logic                   lsb_first_pend_reg;
   logic [ADDR_BITS-1:0]   mux_addr_reg;
   logic                   sample_reg;
   logic                   sample_next;
   logic                   start_reg;
   logic                   eoc_reg;
   logic                   eoc_next;
   logic                   sdo_reg;
   logic                   sdo_oe_reg;

   // Decoded events and selections
   logic                 addr_evt;
   logic                 cmd_evt;
   logic                 fall_evt;
   logic                 frame_on;
   logic                 last_fall;
   logic                 sample_fall;
   logic [CNT_BITS-1:0]  bit_index;
   logic                 bit_value;
   logic                 bits_left;
   cmd_t                 cmd_word;

   // ------------------------------------------------------------------
   // Shift clock side
   // ------------------------------------------------------------------

   // Select high holds the frame counters clear
   assign link_clr = csn | ~resetn;

   // Rising edges count and capture command bits MSB first
   always_ff @(posedge sclk or posedge link_clr) begin
      if (link_clr) begin
         rise_cnt_reg  <= CNT_ZERO;
         cmd_shift_reg <= CMD_RESET;
      end else if (rise_cnt_reg != CMD_RISE) begin
         rise_cnt_reg  <= rise_cnt_reg + CNT_ONE;
         cmd_shift_reg <= {cmd_shift_reg[CMD_BITS-2:0], sdi};
      end
   end

   // Address and command words held steady for the crossing
   always_ff @(posedge sclk or negedge resetn) begin
      if (!resetn) begin
         addr_hold_reg <= ADDR_RESET;
         cmd_hold_reg  <= CMD_RESET;
         addr_tog_reg  <= 1'b0;
         cmd_tog_reg   <= 1'b0;
      end else if (!csn) begin
         if (rise_cnt_reg == ADDR_RISE - CNT_ONE) begin
            addr_hold_reg <= {cmd_shift_reg[ADDR_BITS-2:0], sdi};
            addr_tog_reg  <= ~addr_tog_reg;
         end
         if (rise_cnt_reg == CMD_RISE - CNT_ONE) begin
            cmd_hold_reg <= {cmd_shift_reg[CMD_BITS-2:0], sdi};
            cmd_tog_reg  <= ~cmd_tog_reg;
         end
      end
   end

   // Every falling edge inside a frame is sent over as a toggle
   always_ff @(negedge sclk or negedge resetn) begin
      if (!resetn) begin
         fall_tog_reg <= 1'b0;
      end else if (!csn) begin
         fall_tog_reg <= ~fall_tog_reg;
      end
   end

   // ------------------------------------------------------------------
   // Crossing into the system clock
   // ------------------------------------------------------------------

   sync_2ff #(
      .WIDTH (4)
   ) u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .async_in ({~csn, addr_tog_reg, cmd_tog_reg, fall_tog_reg}), // Cleared stage reads idle
      .sync_out ({sel_s, addr_tog_s, cmd_tog_s, fall_tog_s})
   );

   // Delayed copies for toggle edge detection
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         addr_tog_d_reg <= 1'b0;
         cmd_tog_d_reg  <= 1'b0;
         fall_tog_d_reg <= 1'b0;
      end else begin
         addr_tog_d_reg <= addr_tog_s;
         cmd_tog_d_reg  <= cmd_tog_s;
         fall_tog_d_reg <= fall_tog_s;
      end
   end

   // Event pulses, one system cycle each
   assign addr_evt = addr_tog_s ^ addr_tog_d_reg;
   assign cmd_evt  = cmd_tog_s ^ cmd_tog_d_reg;
   assign fall_evt = fall_tog_s ^ fall_tog_d_reg;
   assign frame_on = sel_s;
   assign cmd_word = cmd_t'(cmd_hold_reg);

   // ------------------------------------------------------------------
   // Output bit selection
   // ------------------------------------------------------------------

   // Falling-edge count of the frame, cleared whenever select is high
   assign fall_cnt_next = !frame_on ? CNT_ZERO :
                          (fall_evt && bits_left) ? fall_cnt_reg + CNT_ONE :
                          fall_cnt_reg;

   // Index walks up or down the previous result
   assign bits_left = fall_cnt_reg != LAST_FALL;
   assign bit_index = lsb_first_reg ? fall_cnt_reg : LAST_INDEX - fall_cnt_reg;
   assign bit_value = bits_left ? result_reg[bit_index] : 1'b0;

   // Frame edges that steer sampling and hand-off
   assign sample_fall = fall_evt && (fall_cnt_reg == SAMPLE_FALL - CNT_ONE);
   assign last_fall   = fall_evt && (fall_cnt_reg == LAST_FALL - CNT_ONE);

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------

   // Next state, sampling window and end-of-conversion flag
   always_comb begin
      state_next  = state_reg;
      sample_next = sample_reg;
      eoc_next    = eoc_reg;
      unique case (state_reg)
         ST_IDLE: begin
            sample_next = 1'b0;
            if (frame_on) begin
               state_next = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (!frame_on) begin
               state_next  = ST_IDLE;
               sample_next = 1'b0;
            end else if (last_fall) begin
               state_next  = ST_CONVERT;
               sample_next = 1'b0;
               eoc_next    = 1'b0;
            end else if (sample_fall) begin
               sample_next = 1'b1;
            end
         end
         ST_CONVERT: begin
            sample_next = 1'b0;
            if (conv_res.done) begin
               state_next = ST_IDLE;
               eoc_next   = 1'b1;
            end
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg    <= ST_IDLE;
         fall_cnt_reg <= CNT_ZERO;
         sample_reg   <= 1'b0;
         eoc_reg      <= 1'b1;
      end else begin
         state_reg    <= state_next;
         fall_cnt_reg <= fall_cnt_next;
         sample_reg   <= sample_next;
         eoc_reg      <= eoc_next;
      end
   end

   // Start pulse to the core on the hand-off
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         start_reg <= 1'b0;
      end else begin
         start_reg <= (state_reg == ST_SHIFT) && frame_on && last_fall;
      end
   end

   // Result word kept until the core delivers a new one
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         result_reg <= RESULT_RESET;
      end else if ((state_reg == ST_CONVERT) && conv_res.done) begin
         result_reg <= conv_res.data;
      end
   end

   // Ordering bit from the command, applied from the next result on
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lsb_first_pend_reg <= 1'b0;
         lsb_first_reg      <= 1'b0;
      end else begin
         if (cmd_evt) begin
            lsb_first_pend_reg <= cmd_word.lsb_first;
         end
         if ((state_reg == ST_CONVERT) && conv_res.done) begin
            lsb_first_reg <= lsb_first_pend_reg;
         end
      end
   end

   // Channel address to the multiplexer after the fourth rise
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mux_addr_reg <= ADDR_RESET;
      end else if (addr_evt) begin
         mux_addr_reg <= addr_hold_reg;
      end
   end

   // Serial output and its enable, driven only inside a frame
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sdo_reg    <= 1'b0;
         sdo_oe_reg <= 1'b0;
      end else begin
         sdo_oe_reg <= frame_on;
         sdo_reg    <= frame_on ? bit_value : 1'b0;
      end
   end

   // Outputs straight from registers
   assign sdo                 = sdo_reg;
   assign sdo_oe              = sdo_oe_reg;
   assign eoc                 = eoc_reg;
   assign conv_req.mux_addr   = mux_addr_reg;
   assign conv_req.sample_en  = sample_reg;
   assign conv_req.conv_start = start_reg;

endmodule

// File: adc_seq_assertions.sv
// Checker for the serial shift sequencer, watching its top ports.
// Assumes the clk domain view; bit order on the wire is judged by the bench.
`timescale 1ns/1ps
module adc_seq_checker
   import adc_seq_pkg::*;
(
   // Clocks and reset
   input wire logic                   clk,
   input wire logic                   resetn,
   input wire logic                   sclk,
   // Host port
   input wire logic                   csn,
   input wire logic                   sdi,
   input wire logic                   sdo,
   input wire logic                   sdo_oe,
   input wire logic                   eoc,
   // Core side
   input wire adc_seq_pkg::conv_res_t conv_res,
   input wire adc_seq_pkg::conv_req_t conv_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // Hand-off steps: flag drops together with a single start pulse
   sequence seq_drop;
      $fell(eoc);
   endsequence
   sequence seq_pulse;
      conv_req.conv_start ##1 !conv_req.conv_start;
   endsequence

   // Output enable and idle level
   chk_oe_idle: assert property (csn [*5] |-> !sdo_oe)
      else $error("data out driven while deselected");
   chk_oe_sel: assert property ((!csn) [*5] |-> sdo_oe)
      else $error("data out not driven while selected");
   chk_sdo_quiet: assert property (!sdo_oe |-> !sdo)
      else $error("data out not zero while released");
   // Conversion hand-off and flag
   chk_handoff_seq: assert property (seq_drop |-> seq_pulse)
      else $error("flag drop without one start pulse");
   chk_eoc_hold: assert property (!eoc && !conv_res.done |=> !eoc)
      else $error("flag rose without done");
   chk_eoc_done: assert property (!eoc && conv_res.done |=> eoc)
      else $error("flag stayed low after done");
   chk_eoc_cause: assert property ($rose(eoc) |-> $past(conv_res.done))
      else $error("flag rose with no done before");
   chk_start_ctx: assert property (conv_req.conv_start |-> !eoc && !conv_req.sample_en)
      else $error("start while flag high or sampling");
   // Address and sampling only inside a frame
   chk_mux_sel: assert property ($changed(conv_req.mux_addr) |-> !csn && sdo_oe)
      else $error("address changed outside a frame");
   chk_sample_sel: assert property ($rose(conv_req.sample_en) |-> !csn && eoc)
      else $error("sampling opened outside a fresh frame");
endmodule

bind adc_serial_shift_sequencer adc_seq_checker u_chk (
   .clk(clk), .resetn(resetn), .sclk(sclk), .csn(csn), .sdi(sdi), .sdo(sdo),
   .sdo_oe(sdo_oe), .eoc(eoc), .conv_res(conv_res), .conv_req(conv_req));

// File: adc_host_model.sv
// Host serial port model: sends a command, reads the result word.
// Assumes the bench hands it the resolved level of the data-out line.
`timescale 1ns/1ps
module adc_host_model (
   // Host port lines
   output logic      sclk,
   output logic      csn,
   output logic      sdi,
   // Resolved data-out line
   input  wire logic sdo_line
);
   localparam realtime HALF = 126.5ns;

   // Idle: deselected, shift clock still
   initial begin
      sclk = 1'b0;
      csn = 1'b1;
      sdi = 1'b0;
   end

   // One frame; first bit seen lands in rx bit 11
   task automatic run_frame(input logic [7:0] cmd, input int falls, output logic [11:0] rx);
      rx = '0;
      csn <= 1'b0;
      #200.3ns;
      for (int k = 0; k < falls; k++) begin
         sdi <= (k < 8) ? cmd[7-k] : ~sdi;
         #HALF;
         rx[11-k] = sdo_line;
         sclk <= 1'b1;
         #HALF;
         sclk <= 1'b0;
      end
      #20ns;
      csn <= 1'b1;
      sdi <= ~sdi;
      #100ns;
   endtask
endmodule

// File: adc_serial_shift_sequencer_bench.sv
// Bench for the serial shift sequencer: host frames in, core stand-in answers.
// Assumes the host model and the checker are compiled before this file.
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module adc_serial_shift_sequencer_bench;
   import adc_seq_pkg::*;
   logic        clk;
   logic        resetn;
   logic        sclk;
   logic        csn;
   logic        sdi;
   logic        sdo;
   logic        sdo_oe;
   logic        eoc;
   logic        last_sdo = 1'b0;
   wire logic   sdo_line;
   conv_res_t   conv_res = '0;
   conv_req_t   conv_req;
   logic [11:0] core_data;
   int          core_cnt = 0;
   int          start_cnt = 0;
   int          error_cnt;
   int          check_count;

   adc_serial_shift_sequencer u_adc_serial_shift_sequencer (.clk(clk), .resetn(resetn),
      .sclk(sclk), .csn(csn), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .eoc(eoc),
      .conv_res(conv_res), .conv_req(conv_req));
   adc_host_model u_adc_host_model (.sclk(sclk), .csn(csn), .sdi(sdi), .sdo_line(sdo_line));

   // Released line shows the inverse of its last driven level
   assign sdo_line = sdo_oe ? sdo : ~last_sdo;

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Core stand-in: done with data ten clocks after a start
   always @(posedge clk) begin
      if (sdo_oe) last_sdo <= sdo;
      conv_res.done <= (core_cnt == 1);
      conv_res.data <= core_data;
      if (conv_req.conv_start) begin
         core_cnt <= 10;
         start_cnt <= start_cnt + 1;
      end else if (core_cnt > 0) begin
         core_cnt <= core_cnt - 1;
      end
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Full frame: word read, window, address, flag and start count
   task automatic do_frame(input logic [7:0] cmd, input logic [11:0] exp_rx,
                           input logic [11:0] data_next);
      logic [11:0] rx;
      logic [11:0] en;
      logic [3:0]  mux;
      int          s0;
      int          n;
      s0 = start_cnt;
      core_data <= data_next;
      fork
         u_adc_host_model.run_frame(cmd, 12, rx);
         for (int k = 0; k < 12; k++) begin
            @(posedge sclk);
            en[k] = conv_req.sample_en;
            if (k == 4) mux = conv_req.mux_addr;
         end
      join
      `CHECK("rx_word", exp_rx, rx)
      `CHECK("sample_win", 12'hff0, en)
      `CHECK("mux_addr", cmd[7:4], mux)
      @(negedge clk);
      `CHECK("eoc_low", 1'b0, eoc)
      n = 0;
      while (eoc !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n == 100) begin
         error_cnt++;
         tally_and_finish();
      end
      `CHECK("starts", s0 + 1, start_cnt)
      $display("frame cmd %h done", cmd);
   endtask

   // Short frame: no hand-off, then a clean frame
   task automatic t_abort;
      logic [11:0] rx;
      int          s0;
      s0 = start_cnt;
      u_adc_host_model.run_frame(8'hff, 6, rx);
      repeat (20) @(negedge clk);
      `CHECK("abort_eoc", 1'b1, eoc)
      `CHECK("abort_start", s0, start_cnt)
      `CHECK("abort_oe", 1'b0, sdo_oe)
      do_frame(8'h00, 12'h0f0, 12'h5a5);
      $display("abort test done");
   endtask

   // Reset, then frames in both bit orders
   initial begin
      resetn = 1'b0;
      core_data = 12'h000;
      error_cnt = 0;
      check_count = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      `CHECK("rst_oe", 1'b0, sdo_oe)
      `CHECK("rst_eoc", 1'b1, eoc)
      `CHECK("rst_req", 6'h00, conv_req)
      $display("reset test done");
      repeat (3) @(posedge clk);
      do_frame(8'h50, 12'h000, 12'ha5c);
      do_frame(8'h32, 12'ha5c, 12'h3c1);
      do_frame(8'hc0, 12'h83c, 12'h0f0);
      t_abort();
      tally_and_finish();
   end
endmodule
